// file: hw/ied_pkg.sv
// Purpose: shared constants and types for the interrupt entry and dispatch unit
// Assumes: 16-bit status word, 21-bit byte addresses, 32-bit APB data
// Notes:   register offsets are byte addresses on the APB bus
package ied_pkg;

  localparam int ADDR_W  = 21;
  localparam int WORD_W  = 16;
  localparam int VEC_W   = 5;
  localparam int IRQ_N   = 16;

  // apb register map
  localparam logic [7:0] OFF_BASE = 8'h00;
  localparam logic [7:0] OFF_ISP  = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;

  // dispatch base keeps only bits 15..1
  localparam logic [20:0] BASE_MASK = 21'h00fffe;
  localparam logic [20:0] BASE_RST  = 21'h000000;
  localparam logic [20:0] ISP_RST   = 21'h000000;
  localparam logic [20:0] ISP_STEP  = 21'h000004;
  localparam logic [20:0] WORD_STEP = 21'h000002;

  // status word bit positions
  localparam int PSW_T = 1;
  localparam int PSW_E = 9;
  localparam int PSW_P = 10;
  localparam int PSW_I = 11;
  localparam logic [15:0] PSW_CLR_MASK = 16'h0c02;

  // vector numbers
  localparam logic [4:0] VEC_NMI    = 5'h01;
  localparam logic [4:0] VEC_SVC    = 5'h05;
  localparam logic [4:0] VEC_DIVZ   = 5'h06;
  localparam logic [4:0] VEC_FLAG   = 5'h07;
  localparam logic [4:0] VEC_BKPT   = 5'h08;
  localparam logic [4:0] VEC_TRACE  = 5'h09;
  localparam logic [4:0] VEC_UNDEF  = 5'h0a;
  localparam logic [4:0] VEC_IRQ0   = 5'h10;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEC_SP, ST_PUSH_PC, ST_PUSH_PSW, ST_CLR_BITS, ST_READ_VEC,
    ST_FETCH, ST_LOAD_PC, ST_POP_PC, ST_POP_PSW, ST_INC_SP
  } ied_state_t;

endpackage

// file: hw/ied_vec_if.sv
// Purpose: carries request sources and the chosen vector between sequencer and selector
// Assumes: all signals synchronous to the one system clock
// Notes:   freeze holds the chosen vector steady during an entry sequence
`timescale 1ns/1ps
interface ied_vec_if;
  logic [15:0] irq;
  logic        nmi;
  logic        trapReq;
  logic [4:0]  trapVec;
  logic        globalEn;
  logic        localEn;
  logic        freeze;
  logic        valid;
  logic [4:0]  vector;

  modport seq (output irq, nmi, trapReq, trapVec, globalEn, localEn, freeze, input valid, vector);
  modport sel (input irq, nmi, trapReq, trapVec, globalEn, localEn, freeze, output valid, vector);
endinterface

// file: hw/ied_vector_select.sv
// Purpose: picks the vector of the highest priority pending exception source
// Assumes: requests are levels held until serviced
// Notes:   output registered; frozen while the sequencer runs an entry
`timescale 1ns/1ps
module ied_vector_select
  import ied_pkg::*;
(
  input  wire logic clock,   // system clock
  input  wire logic rst_n,   // synchronous reset, active low
  input  wire logic ce,      // clock enable
  ied_vec_if.sel    vif      // sources in, vector out
);

  logic       validReg;
  logic       validNext;
  logic [4:0] vectorReg;
  logic [4:0] vectorNext;

  always_comb begin
    validNext  = validReg;
    vectorNext = vectorReg;
    if (!vif.freeze) begin
      validNext  = 1'b0;
      vectorNext = 5'h00;
      // ascending scan: the last hit is the highest numbered request
      if (vif.globalEn && vif.localEn) begin
        for (int n = 0; n < IRQ_N; n++) begin
          if (vif.irq[n]) begin
            validNext  = 1'b1;
            vectorNext = VEC_IRQ0 + 5'(n);
          end
        end
      end
      if (vif.trapReq) begin
        validNext  = 1'b1;
        vectorNext = vif.trapVec;
      end
      if (vif.nmi) begin
        validNext  = 1'b1;
        vectorNext = VEC_NMI;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      validReg  <= 1'b0;
      vectorReg <= 5'h00;
    end else if (ce) begin
      validReg  <= validNext;
      vectorReg <= vectorNext;
    end
  end

  assign vif.valid  = validReg;
  assign vif.vector = vectorReg;

  AST_NMI_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && vif.nmi && !vif.freeze) |=> (vif.valid && vif.vector == VEC_NMI))
    else $error("pending nmi did not win vector selection");

endmodule // ied_vector_select

// file: hw/ied_dispatch_unit.sv
// Purpose: interrupt entry and return sequencing with dispatch table lookup
// Assumes: memory answers each request with a one-cycle memAck; core holds requests until idle
// Notes:   apb answers in the first access cycle; registers at offsets 00,04,08,0c
//
// Summary of operation
// - drop stack pointer by four first
// - push program counter and status word
// - clear global enable, trace pending, trace
// - then read the pending vector number
// - fetch entry at base plus twice vector
// - return restores pc, status, stack plus four
// - target is zero-extended entry shifted left
// - base 21 bits, top five and bit0 zero
// - table holds 32 word entries, vectors 0-31
// - fixed vectors for nmi and the traps; traps here take their vector from the trapVec input
// - nmi beats all, taken on falling edge
// - maskable needs global and local enable
// - highest numbered maskable request served first
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module ied_dispatch_unit
  import ied_pkg::*;
(
  input  wire logic        clock,         // system clock, 200 MHz
  input  wire logic        rst_n,         // synchronous reset, active low
  input  wire logic        ce,            // clock enable, freezes all state when low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error on unmapped address
  input  wire logic        nmiPin_n,      // non-maskable request pin, falling edge
  input  wire logic [15:0] irqReq,        // maskable request levels
  input  wire logic        trapReq,       // core trap request
  input  wire logic [4:0]  trapVec,       // vector of the core trap
  input  wire logic        instrBoundary, // core may be interrupted now
  input  wire logic        retxReq,       // return from exception executing
  input  wire logic [20:0] pcIn,          // current program counter
  input  wire logic [15:0] pswIn,         // current status word
  output logic             busy,          // sequence running, core stalls
  output logic             pcLoad,        // load pcOut into program counter
  output logic      [20:0] pcOut,         // new program counter
  output logic             pswLoad,       // load pswOut into status word
  output logic      [15:0] pswOut,        // new status word
  output logic             entryDone,     // entry finished, pulse
  output logic             memReq,        // memory request
  output logic             memWrite,      // memory direction
  output logic      [20:0] memAddr,       // memory byte address
  output logic      [15:0] memWdata,      // memory write word
  input  wire logic [15:0] memRdata,      // memory read word
  input  wire logic        memAck         // memory answer, one cycle
);
  ied_vec_if vif();
  ied_state_t  stateReg,    stateNext;
  logic [20:0] ispReg,      ispNext;
  logic [20:0] baseReg,     baseNext;
  logic        nmiEnReg,    nmiEnNext;
  logic        nmiPrevReg,  nmiPrevNext;
  logic        nmiPendReg,  nmiPendNext;
  logic [4:0]  vecReg,      vecNext;
  logic [20:0] pcSavedReg,  pcSavedNext;
  logic [15:0] pswSavedReg, pswSavedNext;
  logic [20:0] pcOutReg,    pcOutNext;
  logic [15:0] pswOutReg,   pswOutNext;
  logic        pcLoadReg,   pcLoadNext;
  logic        pswLoadReg,  pswLoadNext;
  logic        busyReg,     busyNext;
  logic        doneReg,     doneNext;
  logic        memReqReg,   memReqNext;
  logic        memWrReg,    memWrNext;
  logic [20:0] memAddrReg,  memAddrNext;
  logic [15:0] memWdReg,    memWdNext;
  logic [31:0] prdataReg,   prdataNext;
  logic        preadyReg,   preadyNext;
  logic        pslverrReg,  pslverrNext;
  logic        nmiClr;
  logic        apbWrite;
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_BASE) || (a == OFF_ISP) || (a == OFF_CTRL) || (a == OFF_STAT);
  endfunction
  assign vif.irq      = irqReq;
  assign vif.nmi      = nmiPendReg;
  assign vif.trapReq  = trapReq;
  assign vif.trapVec  = trapVec;
  assign vif.globalEn = pswIn[PSW_I];
  assign vif.localEn  = pswIn[PSW_E];
  // the global enable is cleared mid-entry, so the chosen vector must not follow it
  assign vif.freeze   = (stateReg != ST_IDLE);
  ied_vector_select u_select (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .vif   (vif)
  );
  assign apbWrite = psel && penable && preadyReg && pwrite;
  always_comb begin
    stateNext    = stateReg;
    ispNext      = ispReg;
    baseNext     = baseReg;
    nmiEnNext    = nmiEnReg;
    nmiPrevNext  = nmiPin_n;
    vecNext      = vecReg;
    pcSavedNext  = pcSavedReg;
    pswSavedNext = pswSavedReg;
    pcOutNext    = pcOutReg;
    pswOutNext   = pswOutReg;
    pcLoadNext   = 1'b0;
    pswLoadNext  = 1'b0;
    busyNext     = busyReg;
    doneNext     = 1'b0;
    memReqNext   = memReqReg;
    memWrNext    = memWrReg;
    memAddrNext  = memAddrReg;
    memWdNext    = memWdReg;
    nmiClr       = 1'b0;
    // apb slave: ready in the first access cycle, data prepared in setup
    preadyNext   = psel && !penable;
    pslverrNext  = psel && !penable && !mapped(paddr);
    prdataNext   = prdataReg;
    if (psel && !penable) begin
      unique case (paddr)
        OFF_BASE: prdataNext = {11'h000, baseReg};
        OFF_ISP:  prdataNext = {11'h000, ispReg};
        OFF_CTRL: prdataNext = {31'h00000000, nmiEnReg};
        OFF_STAT: prdataNext = {20'h00000, vecReg, nmiPendReg, busyReg, 1'b0, stateReg};
        default:  prdataNext = 32'h00000000;
      endcase
    end
    if (apbWrite) begin
      unique case (paddr)
        OFF_BASE: baseNext  = pwdata[20:0] & BASE_MASK;
        OFF_ISP:  ispNext   = pwdata[20:0];
        OFF_CTRL: nmiEnNext = pwdata[0];
        default:  ;
      endcase
    end

    unique case (stateReg)
      ST_IDLE: begin
        if (instrBoundary && retxReq) begin
          busyNext  = 1'b1;
          stateNext = ST_POP_PC;
        end else if (instrBoundary && vif.valid && !pcLoadReg) begin // selector output is stale one cycle after a run
          busyNext     = 1'b1;
          pcSavedNext  = pcIn;
          pswSavedNext = pswIn;
          stateNext    = ST_DEC_SP;
        end
      end
      ST_DEC_SP: begin
        ispNext   = ispReg - ISP_STEP;
        stateNext = ST_PUSH_PC;
      end
      ST_PUSH_PC: begin
        if (!memReqReg) begin
          memReqNext  = 1'b1;
          memWrNext   = 1'b1;
          memAddrNext = ispReg;
          memWdNext   = pcSavedReg[16:1];
        end else if (memAck) begin
          memReqNext = 1'b0;
          stateNext  = ST_PUSH_PSW;
        end
      end
      ST_PUSH_PSW: begin
        if (!memReqReg) begin
          memReqNext  = 1'b1;
          memWrNext   = 1'b1;
          memAddrNext = ispReg + WORD_STEP;
          memWdNext   = pswSavedReg;
        end else if (memAck) begin
          memReqNext = 1'b0;
          stateNext  = ST_CLR_BITS;
        end
      end
      ST_CLR_BITS: begin
        pswOutNext  = pswSavedReg & ~PSW_CLR_MASK;
        pswLoadNext = 1'b1;
        stateNext   = ST_READ_VEC;
      end
      ST_READ_VEC: begin
        vecNext   = vif.vector;
        nmiClr    = (vif.vector == VEC_NMI);
        stateNext = ST_FETCH;
      end
      ST_FETCH: begin
        if (!memReqReg) begin
          memReqNext  = 1'b1;
          memWrNext   = 1'b0;
          memAddrNext = baseReg + {15'h0000, vecReg, 1'b0};
        end else if (memAck) begin
          memReqNext = 1'b0;
          pcOutNext  = {4'h0, memRdata, 1'b0};
          stateNext  = ST_LOAD_PC;
        end
      end
      ST_LOAD_PC: begin
        pcLoadNext = 1'b1;
        doneNext   = 1'b1;
        busyNext   = 1'b0;
        stateNext  = ST_IDLE;
      end
      ST_POP_PC: begin
        if (!memReqReg) begin
          memReqNext  = 1'b1;
          memWrNext   = 1'b0;
          memAddrNext = ispReg;
        end else if (memAck) begin
          memReqNext = 1'b0;
          pcOutNext  = {4'h0, memRdata, 1'b0};
          stateNext  = ST_POP_PSW;
        end
      end
      ST_POP_PSW: begin
        if (!memReqReg) begin
          memReqNext  = 1'b1;
          memWrNext   = 1'b0;
          memAddrNext = ispReg + WORD_STEP;
        end else if (memAck) begin
          memReqNext = 1'b0;
          pswOutNext = memRdata;
          stateNext  = ST_INC_SP;
        end
      end
      ST_INC_SP: begin
        ispNext     = ispReg + ISP_STEP;
        pcLoadNext  = 1'b1;
        pswLoadNext = 1'b1;
        busyNext    = 1'b0;
        stateNext   = ST_IDLE;
      end
      default: stateNext = ST_IDLE;
    endcase
    // a new edge in the clearing cycle keeps the request pending
    nmiPendNext = (nmiPendReg && !nmiClr) || (nmiEnReg && nmiPrevReg && !nmiPin_n);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stateReg    <= ST_IDLE;
      ispReg      <= ISP_RST;
      baseReg     <= BASE_RST;
      nmiEnReg    <= 1'b0;
      nmiPrevReg  <= 1'b1;
      nmiPendReg  <= 1'b0;
      vecReg      <= 5'h00;
      pcSavedReg  <= 21'h000000;
      pswSavedReg <= 16'h0000;
      pcOutReg    <= 21'h000000;
      pswOutReg   <= 16'h0000;
      pcLoadReg   <= 1'b0;
      pswLoadReg  <= 1'b0;
      busyReg     <= 1'b0;
      doneReg     <= 1'b0;
      memReqReg   <= 1'b0;
      memWrReg    <= 1'b0;
      memAddrReg  <= 21'h000000;
      memWdReg    <= 16'h0000;
      prdataReg   <= 32'h00000000;
      preadyReg   <= 1'b0;
      pslverrReg  <= 1'b0;
    end else if (ce) begin
      stateReg    <= stateNext;
      ispReg      <= ispNext;
      baseReg     <= baseNext;
      nmiEnReg    <= nmiEnNext;
      nmiPrevReg  <= nmiPrevNext;
      nmiPendReg  <= nmiPendNext;
      vecReg      <= vecNext;
      pcSavedReg  <= pcSavedNext;
      pswSavedReg <= pswSavedNext;
      pcOutReg    <= pcOutNext;
      pswOutReg   <= pswOutNext;
      pcLoadReg   <= pcLoadNext;
      pswLoadReg  <= pswLoadNext;
      busyReg     <= busyNext;
      doneReg     <= doneNext;
      memReqReg   <= memReqNext;
      memWrReg    <= memWrNext;
      memAddrReg  <= memAddrNext;
      memWdReg    <= memWdNext;
      prdataReg   <= prdataNext;
      preadyReg   <= preadyNext;
      pslverrReg  <= pslverrNext;
    end
  end
  assign prdata    = prdataReg;
  assign pready    = preadyReg;
  assign pslverr   = pslverrReg;
  assign busy      = busyReg;
  assign pcLoad    = pcLoadReg;
  assign pcOut     = pcOutReg;
  assign pswLoad   = pswLoadReg;
  assign pswOut    = pswOutReg;
  assign entryDone = doneReg;
  assign memReq    = memReqReg;
  assign memWrite  = memWrReg;
  assign memAddr   = memAddrReg;
  assign memWdata  = memWdReg;
  AST_ISP_DEC: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && stateReg == ST_DEC_SP) |=> (ispReg == $past(ispReg) - ISP_STEP && stateReg == ST_PUSH_PC))
    else $error("stack pointer not lowered by four on entry");
  AST_PUSH_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
    (memReqReg && stateReg == ST_PUSH_PSW) |-> (memWrReg && memAddrReg == ispReg + WORD_STEP
      && memWdReg == pswSavedReg))
    else $error("status word push has wrong address or data");
  AST_CLR_BITS: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && stateReg == ST_CLR_BITS) |=> (pswLoadReg && !pswOutReg[PSW_I] && !pswOutReg[PSW_P] && !pswOutReg[PSW_T]))
    else $error("enable or trace bits not cleared on entry");
  AST_VEC_READ: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && stateReg == ST_READ_VEC) |=> (vecReg == $past(vif.vector) && stateReg == ST_FETCH))
    else $error("vector not captured before table fetch");
  AST_FETCH_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
    (memReqReg && stateReg == ST_FETCH) |-> (!memWrReg && memAddrReg == baseReg + {15'h0000, vecReg, 1'b0}))
    else $error("dispatch entry address wrong");
  AST_RETURN_FROM_EXCEPTION_SP: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && stateReg == ST_INC_SP) |=> (ispReg == $past(ispReg) + ISP_STEP && pcLoadReg && pswLoadReg))
    else $error("return did not raise stack pointer by four");
  AST_TARGET: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && stateReg == ST_FETCH && memReqReg && memAck) |=> (pcOutReg == {4'h0, $past(memRdata), 1'b0}))
    else $error("routine address not built from table entry");
  AST_BASE_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    (baseReg[20:16] == 5'h00 && baseReg[0] == 1'b0))
    else $error("dispatch base holds bits that must read zero");
  // a low enable freezes the pulse, so only its first cycle is judged
  AST_LOAD_AFTER_FETCH: assert property (@(posedge clock) disable iff (!rst_n)
    (pcLoadReg && doneReg && $past(ce)) |-> ($past(stateReg) == ST_LOAD_PC && busyReg == 1'b0))
    else $error("pc loaded outside the entry sequence order");

endmodule // ied_dispatch_unit

// file: testbench/ied_mem_model.sv
// Purpose: word memory standing in for the stack ram and the dispatch table
// Assumes: one request at a time, held by the unit until memAck
// Notes:   read data is inverted while no answer stands, so stale words never look valid
`timescale 1ns/1ps
module ied_mem_model (
  input  wire logic        clock,    // system clock
  input  wire logic        memReq,   // request level
  input  wire logic        memWrite, // direction
  input  wire logic [20:0] memAddr,  // byte address
  input  wire logic [15:0] memWdata, // write word
  input  wire logic [3:0]  waitCyc,  // cycles before the answer
  output logic      [15:0] memRdata, // read word
  output logic             memAck    // one-cycle answer
);
  logic [15:0] mem [int];
  int          cnt;

  initial begin
    memAck   = 1'b0;
    memRdata = 16'h0000;
    cnt      = 0;
  end

  always @(posedge clock) begin
    memAck   <= 1'b0;
    memRdata <= ~memRdata;
    // the ack edge still sees memReq high, so no second answer there
    if (memReq && !memAck) begin
      if (cnt < waitCyc) begin
        cnt <= cnt + 1;
      end else begin
        cnt    <= 0;
        memAck <= 1'b1;
        if (memWrite) begin
          mem[memAddr[20:1]] = memWdata; // blocking: the bench also fills this array directly
        end else begin
          memRdata <= mem.exists(memAddr[20:1]) ? mem[memAddr[20:1]] : 16'h5a5a;
        end
      end
    end
  end
endmodule // ied_mem_model

// file: testbench/interrupt_entry_dispatch_tb.sv
// Purpose: self-checking bench for entry, dispatch and return sequencing
// Assumes: apb answers when pready is seen; memory model answers with varied waits
// Notes:   the pc is kept even and below bit 17 so the saved low word restores it whole
`timescale 1ns/1ps
module interrupt_entry_dispatch_tb
  import ied_pkg::*;
;
  logic        clock, rst_n, ce, psel, penable, pwrite, pready, pslverr, rdErr;
  logic        nmiPin_n, trapReq, instrBoundary, retxReq, busy, pcLoad, pswLoad;
  logic        entryDone, memReq, memWrite, memAck;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [15:0] irqReq, pswIn, pswOut, memWdata, memRdata, gotPsw;
  logic [20:0] pcIn, pcOut, memAddr, gotPc;
  logic [4:0]  trapVec;
  logic [3:0]  memWait;
  int          miscompares, checked, cycles, nDone;
  localparam logic [20:0] TBL  = 21'h001000;
  localparam logic [20:0] ISP0 = 21'h00e800;
  localparam logic [20:0] PC0  = 21'h001234;

  ied_dispatch_unit DUT (.clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .nmiPin_n, .irqReq, .trapReq, .trapVec, .instrBoundary, .retxReq, .pcIn,
    .pswIn, .busy, .pcLoad, .pcOut, .pswLoad, .pswOut, .entryDone, .memReq, .memWrite, .memAddr,
    .memWdata, .memRdata, .memAck);
  ied_mem_model MEM (.clock, .memReq, .memWrite, .memAddr, .memWdata, .waitCyc(memWait),
    .memRdata, .memAck);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (pcLoad === 1'b1) gotPc <= pcOut;
    if (pswLoad === 1'b1) gotPsw <= pswOut;
    if (entryDone === 1'b1) nDone <= nDone + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // table entries stay below 06000 so targets land inside program memory
  function automatic logic [15:0] ent(input logic [4:0] v);
    return 16'h0200 + {11'h000, v};
  endfunction

  function automatic logic [15:0] clrd(input logic [15:0] p);
    logic [15:0] r;
    r = p;
    r[PSW_I] = 1'b0;
    r[PSW_P] = 1'b0;
    r[PSW_T] = 1'b0;
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic endTest(input string s);
    $display("test %s ended", s);
  endtask

  task automatic wrap_up();
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic waitFor(input int which);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((which == 0 ? busy : which == 1 ? entryDone : pcLoad) !== 1'b1 && n < 400);
    if (n >= 400) begin
      miscompares++;
      $display("unexpected at %0t: no answer", $time);
      wrap_up();
    end
  endtask

  // one entry then its return; boundary drops once busy shows, so no restart
  task automatic serve(input logic tr, input logic [4:0] tv, input logic [15:0] irq,
                       input logic [15:0] psw, input logic [4:0] v);
    trapReq <= tr;
    trapVec <= tv;
    irqReq  <= irq;
    pswIn   <= psw;
    repeat (3) @(posedge clock);
    instrBoundary <= 1'b1;
    waitFor(0);
    instrBoundary <= 1'b0;
    waitFor(1);
    trapReq <= 1'b0;
    irqReq  <= 16'h0000;
    @(posedge clock);
    chk(32'(gotPc), {15'h0000, ent(v), 1'b0});
    chk(32'(gotPsw), 32'(clrd(psw)));
    chk(32'(MEM.mem[(ISP0 - 21'h000004) >> 1]), 32'(PC0[16:1]));
    chk(32'(MEM.mem[(ISP0 - 21'h000002) >> 1]), 32'(psw));
    apb(1'b0, OFF_ISP, 32'h0);
    chk(rdData, 32'(ISP0 - 21'h000004));
    retxReq       <= 1'b1;
    instrBoundary <= 1'b1;
    waitFor(0);
    retxReq       <= 1'b0;
    instrBoundary <= 1'b0;
    waitFor(2);
    @(posedge clock);
    chk(32'(gotPc), 32'(PC0));
    chk(32'(gotPsw), 32'(psw));
    apb(1'b0, OFF_ISP, 32'h0);
    chk(rdData, 32'(ISP0));
  endtask

  initial begin
    int nd;
    {rst_n, ce, psel, penable, pwrite, nmiPin_n, trapReq, instrBoundary, retxReq} = 9'b010001000;
    {paddr, pwdata, irqReq, trapVec, pswIn, memWait} = '0;
    pcIn = PC0;
    {miscompares, checked, cycles, nDone} = '0;
    {gotPc, gotPsw} = '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, OFF_BASE, 32'h0);
    chk(rdData, 32'h00000000);
    apb(1'b0, OFF_ISP, 32'h0);
    chk(rdData, 32'h00000000);
    apb(1'b1, OFF_BASE, 32'hffffffff);
    apb(1'b0, OFF_BASE, 32'h0);
    chk(rdData, 32'h0000fffe);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, rdErr}, 32'h00000001);
    endTest("registers");
    apb(1'b1, OFF_BASE, 32'(TBL));
    apb(1'b1, OFF_ISP, 32'(ISP0));
    for (int v = 0; v < 32; v++) MEM.mem[(TBL >> 1) + v] = ent(5'(v));
    for (int v = 5; v <= 10; v++) begin
      memWait <= 4'(v % 3);
      serve(1'b1, 5'(v), 16'h0000, 16'hffff, 5'(v));
    end
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rdData, 32'h00000500);
    endTest("traps");
    serve(1'b0, 5'h00, 16'h0041, 16'h0a00, 5'd22);
    serve(1'b0, 5'h00, 16'h0001, 16'h0e00, 5'd16);
    serve(1'b0, 5'h00, 16'h8000, 16'h0a00, 5'd31);
    for (int i = 0; i < 2; i++) begin
      nd = nDone;
      pswIn  <= i ? 16'h0200 : 16'h0800;
      irqReq <= 16'h0004;
      instrBoundary <= 1'b1;
      repeat (30) @(posedge clock);
      chk(32'(nDone), 32'(nd));
      instrBoundary <= 1'b0;
      irqReq <= 16'h0000;
      @(posedge clock);
    end
    endTest("maskable");
    // a frozen unit must not start an entry on a standing trap
    ce            <= 1'b0;
    trapReq       <= 1'b1;
    instrBoundary <= 1'b1;
    repeat (10) @(posedge clock);
    chk({31'h0, busy}, 32'h00000000);
    ce            <= 1'b1;
    trapReq       <= 1'b0;
    instrBoundary <= 1'b0;
    @(posedge clock);
    endTest("clock enable");
    apb(1'b1, OFF_CTRL, 32'h00000001);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rdData, 32'h00000001);
    nmiPin_n <= 1'b0;
    serve(1'b1, 5'd8, 16'h8000, 16'h0a00, 5'd1);
    // pin held low: a level must not request again
    serve(1'b1, 5'd8, 16'h0000, 16'h0a00, 5'd8);
    endTest("nmi");
    wrap_up();
  end
endmodule // interrupt_entry_dispatch_tb
